/* hw/watchdog_option_byte_config.sv */
// Overview of operation
// - Auto-start 0 keeps the counter stopped after reset, 1 starts it.
// - Window code 01B opens 50 %, 10B 75 %, 11B 100 % of overflow time.
// - Interval-interrupt bit 1 raises interval requests, 0 raises none.
// - Auto-start 1 forces invalid memory access detection on.
// - Writing key ACH to the clear register inside the open window restarts the count.
// - Standby-count bit 0 forces a 100 % window, ignoring the field.
// - Overflow-time code selects one of eight power-of-two periods.
// - The option byte is captured at every reset release.
//
// Implementation choice: the APB slave port.
module watchdog_option_byte_config #(
	parameter int LoscDiv = wdt_cfg_pkg::LOSC_DIV
) (
	input  wire logic        clock,          // 40 MHz bus clock
	input  wire logic        rst_n,          // Synchronous reset
	input  wire logic        psel,           // APB select
	input  wire logic        penable,        // APB enable
	input  wire logic        pwrite,         // APB direction
	input  wire logic [7:0]  paddr,          // APB byte address
	input  wire logic [31:0] pwdata,         // APB write data
	output logic      [31:0] prdata,         // APB read data
	output logic             pready,         // APB ready
	output logic             pslverr,        // APB error, unmapped
	input  wire logic [7:0]  optionByte,     // Nonvolatile option byte
	input  wire logic        standbyMode,    // Halt or stop mode
	output logic             irq,            // Level interrupt
	output logic             wdtResetReq,    // Held until system reset
	output logic             illegalAccessEn // Access detection on
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [7:0] optMeta_reg, optSync_reg;
	logic       stbyMeta_reg, stbySync_reg;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			optMeta_reg  <= 8'h00;
			optSync_reg  <= 8'h00;
			stbyMeta_reg <= 1'b0;
			stbySync_reg <= 1'b0;
		end else begin
			optMeta_reg  <= optionByte;
			optSync_reg  <= optMeta_reg;
			stbyMeta_reg <= standbyMode;
			stbySync_reg <= stbyMeta_reg;
		end
	end

	function automatic logic [16:0] ovfPeriod(input logic [2:0] sel);
		logic [4:0] e;
		e = 5'h6;
		case (sel)
			3'h0: e = 5'h6;
			3'h1: e = 5'h7;
			3'h2: e = 5'h8;
			3'h3: e = 5'h9;
			3'h4: e = 5'hb;
			3'h5: e = 5'hd;
			3'h6: e = 5'he;
			default: e = 5'h10;
		endcase
		ovfPeriod = 17'h1 << e;
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	wdt_cfg_pkg::wdt_state_t   state_reg, state_next;
	wdt_cfg_pkg::option_byte_t opt_reg, opt_next;
	logic [1:0]  load_reg, load_next;
	logic [15:0] div_reg, div_next;
	logic [16:0] cnt_reg, cnt_next;
	logic [2:0]  status_reg, status_next;
	logic [2:0]  mask_reg, mask_next;
	logic        iactl_reg, iactl_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        ready_reg, ready_next;
	logic        err_reg, err_next;
	logic        irq_reg, irq_next;
	logic        trip_reg, trip_next;
	logic        iaEn_reg, iaEn_next;

	wdt_cfg_pkg::apb_req_t req;
	logic        tick, wrDone, clrWrite, winOpen, countOn, mapped;
	logic [16:0] period, winStart;
	logic [2:0]  setBits, w1c;

	assign req = '{psel, penable, pwrite, paddr, pwdata};

	always_comb begin
		period   = ovfPeriod(opt_reg.overflowTimeSelect);
		winStart = 17'h0;
		if (opt_reg.standbyCountEnable) begin
			case (opt_reg.window)
				wdt_cfg_pkg::WIN_50: winStart = period >> 1;
				wdt_cfg_pkg::WIN_75: winStart = period >> 2;
				default:             winStart = 17'h0;
			endcase
		end
		winOpen = cnt_reg >= winStart;
		tick    = div_reg == 16'(LoscDiv - 1);
		// Frozen in standby unless counting there is enabled
		countOn = (state_reg == wdt_cfg_pkg::RUNNING) &&
			(!stbySync_reg || opt_reg.standbyCountEnable);
		mapped  = req.paddr inside {wdt_cfg_pkg::ADDR_CLEAR,
			wdt_cfg_pkg::ADDR_IACTL, wdt_cfg_pkg::ADDR_STATUS,
			wdt_cfg_pkg::ADDR_MASK, wdt_cfg_pkg::ADDR_COUNT,
			wdt_cfg_pkg::ADDR_OPTBYTE};
		wrDone   = req.psel && req.penable && ready_reg && req.pwrite &&
			!err_reg;
		clrWrite = wrDone && req.paddr == wdt_cfg_pkg::ADDR_CLEAR;

		// Defaults
		state_next  = state_reg;
		opt_next    = opt_reg;
		load_next   = load_reg;
		div_next    = tick ? 16'h0 : div_reg + 16'h1;
		cnt_next    = cnt_reg;
		mask_next   = mask_reg;
		iactl_next  = iactl_reg;
		trip_next   = trip_reg;
		setBits     = 3'h0;
		w1c         = 3'h0;

		case (state_reg)
			wdt_cfg_pkg::LOADING: begin
				// Waits for the synchronised byte before latching
				load_next = load_reg + 2'h1;
				if (load_reg == 2'(wdt_cfg_pkg::LOAD_CYCLES)) begin
					opt_next   = optSync_reg;
					state_next = optSync_reg[4] ?
						wdt_cfg_pkg::RUNNING : wdt_cfg_pkg::STOPPED;
				end
			end
			wdt_cfg_pkg::RUNNING: begin
				if (clrWrite) begin
					if (req.pwdata[7:0] == wdt_cfg_pkg::CLEAR_KEY &&
						winOpen) begin
						cnt_next = 17'h0;
					end else begin
						setBits[wdt_cfg_pkg::ST_WINDOW] = 1'b1;
						state_next = wdt_cfg_pkg::TRIPPED;
					end
				end else if (countOn && tick) begin
					if (cnt_reg == period - 17'h1) begin
						setBits[wdt_cfg_pkg::ST_OVERFLOW] = 1'b1;
						state_next = wdt_cfg_pkg::TRIPPED;
					end else begin
						cnt_next = cnt_reg + 17'h1;
					end
					// Interval request at 75 % of overflow
					if (opt_reg.intervalIrqEnable &&
						cnt_reg == period - (period >> 2) - 17'h1)
						setBits[wdt_cfg_pkg::ST_INTERVAL] = 1'b1;
				end
			end
			wdt_cfg_pkg::TRIPPED: trip_next = 1'b1;
			wdt_cfg_pkg::STOPPED: cnt_next = 17'h0;
			default: state_next = wdt_cfg_pkg::LOADING;
		endcase

		if (wrDone && req.paddr == wdt_cfg_pkg::ADDR_STATUS)
			w1c = req.pwdata[2:0];
		if (wrDone && req.paddr == wdt_cfg_pkg::ADDR_MASK)
			mask_next = req.pwdata[2:0];
		if (wrDone && req.paddr == wdt_cfg_pkg::ADDR_IACTL)
			iactl_next = req.pwdata[wdt_cfg_pkg::IACTL_EN_BIT];
		// Set beats a same-cycle clear
		status_next = (status_reg & ~w1c) | setBits;
		irq_next    = |(status_next & mask_next);
		iaEn_next   = iactl_next || opt_next.autostartEnable;

		// One wait state: answer in the second access cycle
		ready_next = req.psel && req.penable && !ready_reg;
		err_next   = ready_next && !mapped;
		rdata_next = rdata_reg;
		if (ready_next) begin
			case (req.paddr)
				wdt_cfg_pkg::ADDR_IACTL:   rdata_next = {31'h0, iactl_reg};
				wdt_cfg_pkg::ADDR_STATUS:  rdata_next = {29'h0, status_reg};
				wdt_cfg_pkg::ADDR_MASK:    rdata_next = {29'h0, mask_reg};
				wdt_cfg_pkg::ADDR_COUNT:   rdata_next = {15'h0, cnt_reg};
				wdt_cfg_pkg::ADDR_OPTBYTE: rdata_next = {24'h0, opt_reg};
				default:                   rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg  <= wdt_cfg_pkg::LOADING;
			opt_reg    <= wdt_cfg_pkg::OPT_RESET;
			load_reg   <= 2'h0;
			div_reg    <= 16'h0;
			cnt_reg    <= 17'h0;
			status_reg <= wdt_cfg_pkg::STATUS_RESET;
			mask_reg   <= wdt_cfg_pkg::MASK_RESET;
			iactl_reg  <= wdt_cfg_pkg::IACTL_RESET;
			rdata_reg  <= 32'h0;
			ready_reg  <= 1'b0;
			err_reg    <= 1'b0;
			irq_reg    <= 1'b0;
			trip_reg   <= 1'b0;
			iaEn_reg   <= 1'b0;
		end else begin
			state_reg  <= state_next;
			opt_reg    <= opt_next;
			load_reg   <= load_next;
			div_reg    <= div_next;
			cnt_reg    <= cnt_next;
			status_reg <= status_next;
			mask_reg   <= mask_next;
			iactl_reg  <= iactl_next;
			rdata_reg  <= rdata_next;
			ready_reg  <= ready_next;
			err_reg    <= err_next;
			irq_reg    <= irq_next;
			trip_reg   <= trip_next;
			iaEn_reg   <= iaEn_next;
		end
	end

	assign prdata          = rdata_reg;
	assign pready          = ready_reg;
	assign pslverr         = err_reg;
	assign irq             = irq_reg;
	assign wdtResetReq     = trip_reg;
	assign illegalAccessEn = iaEn_reg;

endmodule // watchdog_option_byte_config

/* pkg/wdt_cfg_pkg.sv */
package wdt_cfg_pkg;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] ADDR_CLEAR    = 8'h00;
	localparam logic [7:0] ADDR_IACTL    = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_MASK     = 8'h0c;
	localparam logic [7:0] ADDR_COUNT    = 8'h10;
	localparam logic [7:0] ADDR_OPTBYTE  = 8'hc0;

	// ****************************************************************
	// Field positions and values
	// ****************************************************************
	localparam logic [7:0] CLEAR_KEY     = 8'hac;
	localparam int         IACTL_EN_BIT  = 0;
	localparam int         ST_INTERVAL   = 0;
	localparam int         ST_OVERFLOW   = 1;
	localparam int         ST_WINDOW     = 2;
	localparam int         ST_WIDTH      = 3;
	localparam logic [2:0] STATUS_RESET  = 3'h0;
	localparam logic [2:0] MASK_RESET    = 3'h0;
	localparam logic       IACTL_RESET   = 1'b0;
	localparam logic [7:0] OPT_RESET     = 8'h00;

	localparam logic [1:0] WIN_50        = 2'h1;
	localparam logic [1:0] WIN_75        = 2'h2;
	localparam logic [1:0] WIN_100       = 2'h3;

	localparam int         CNT_WIDTH     = 17;
	localparam int         LOAD_CYCLES   = 2;

	// ****************************************************************
	// Timing: low-speed oscillator tick derived from the bus clock
	// ****************************************************************
	localparam int CLK_PERIOD_PS  = 25000;
	localparam int LOSC_PERIOD_PS = 66666667;
	localparam int LOSC_DIV       = LOSC_PERIOD_PS / CLK_PERIOD_PS;

	// Option byte layout, bit 7 down to bit 0
	typedef struct packed {
		logic       intervalIrqEnable;
		logic [1:0] window;
		logic       autostartEnable;
		logic [2:0] overflowTimeSelect;
		logic       standbyCountEnable;
	} option_byte_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef enum {LOADING, RUNNING, STOPPED, TRIPPED} wdt_state_t;

endpackage

/* bench/wdt_cfg_checker.sv */
// ****************************************************************
// Port-level checks of the option byte watchdog
// ****************************************************************
module wdt_cfg_checker (
	input wire logic        clock,          // Clock
	input wire logic        rst_n,          // Reset
	input wire logic        psel,           // APB
	input wire logic        penable,        // APB
	input wire logic        pwrite,         // APB
	input wire logic [7:0]  paddr,          // APB
	input wire logic [31:0] pwdata,         // APB
	input wire logic [31:0] prdata,         // APB
	input wire logic        pready,         // APB
	input wire logic        pslverr,        // APB
	input wire logic [7:0]  optionByte,     // Option byte
	input wire logic        standbyMode,    // Standby
	input wire logic        irq,            // Interrupt
	input wire logic        wdtResetReq,    // Reset request
	input wire logic        illegalAccessEn // Access detection
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic mapped;
	assign mapped = paddr inside {wdt_cfg_pkg::ADDR_CLEAR,
		wdt_cfg_pkg::ADDR_IACTL, wdt_cfg_pkg::ADDR_STATUS,
		wdt_cfg_pkg::ADDR_MASK, wdt_cfg_pkg::ADDR_COUNT,
		wdt_cfg_pkg::ADDR_OPTBYTE};
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready not after one wait state");
	a_err_map: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr wrong for address");
	a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_trip_held: assert property (wdtResetReq |=> wdtResetReq)
		else $error("reset request dropped");
	a_iactl_on: assert property (psel && penable && pready && pwrite &&
		paddr == wdt_cfg_pkg::ADDR_IACTL && pwdata[0] |-> ##[1:3] illegalAccessEn)
		else $error("access detection not enabled by register");
	a_auto_on: assert property ($rose(rst_n) && optionByte[4]
		|-> ##[3:8] illegalAccessEn) else $error("autostart not forcing detection");
	a_opt_read: assert property (pready && !pwrite &&
		paddr == wdt_cfg_pkg::ADDR_OPTBYTE |-> prdata == {24'h0, optionByte})
		else $error("option byte readback wrong");
	a_out_quiet: assert property ($rose(rst_n) |-> !irq && !wdtResetReq && !pready)
		else $error("outputs active after reset");
	cover property (wdtResetReq);
	cover property (irq);
	cover property (pready && pslverr);
endmodule // wdt_cfg_checker

bind watchdog_option_byte_config wdt_cfg_checker wdt_cfg_checker_i (
	.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .optionByte(optionByte),
	.standbyMode(standbyMode), .irq(irq), .wdtResetReq(wdtResetReq),
	.illegalAccessEn(illegalAccessEn));

/* bench/tb_top.sv */
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int Div = 2;
	logic        clock, rst_n, psel, penable, pwrite, standbyMode, errv;
	logic [7:0]  paddr, optionByte;
	logic [31:0] pwdata, prdata, rdv, c0, wd;
	logic        pready, pslverr, irq, wdtResetReq, illegalAccessEn;
	int          failures, n_compared, n, c;
	int tWin[7] = '{1, 1, 2, 2, 3, 3, 1};
	int tSb[7] = '{1, 1, 1, 1, 1, 1, 0};
	int tWait[7] = '{0, 80, 0, 40, 0, 0, 0};
	int tKey[7] = '{1, 1, 1, 1, 1, 0, 1};
	int tTrip[7] = '{1, 0, 1, 0, 0, 1, 0};
	watchdog_option_byte_config #(.LoscDiv(Div)) watchdog_option_byte_config_i (
		.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .optionByte(optionByte),
		.standbyMode(standbyMode), .irq(irq), .wdtResetReq(wdtResetReq),
		.illegalAccessEn(illegalAccessEn));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic int period(input int code);
		int t[8] = '{6, 7, 8, 9, 11, 13, 14, 16};
		return 1 << t[code];
	endfunction
	function automatic logic [7:0] opt(input int i, w, a, o, s);
		return {i[0], w[1:0], a[0], o[2:0], s[0]};
	endfunction
	task automatic tally_and_finish();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Answer and read data are taken at the edge that sees pready high
	task automatic apb(input int w, input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w[0];
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) failures++;
	endtask
	task automatic reset_with(input logic [7:0] ob);
		rst_n <= 1'b0;
		optionByte <= ob;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		repeat (5) @(posedge clock);
		apb(0, wdt_cfg_pkg::ADDR_OPTBYTE, 0);
		`CHK("optbyte", {24'h0, ob}, rdv)
	endtask
	initial begin
		repeat (60000) @(posedge clock);
		failures++;
		tally_and_finish();
	end
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		{rst_n, psel, penable, pwrite, standbyMode} = 5'h0;
		{paddr, optionByte, pwdata} = 48'h0;
		{failures, n_compared} = 64'h0;
		c = $urandom(61);
		reset_with(opt(0, 3, 0, 0, 1));
		repeat (20) @(posedge clock);
		apb(0, wdt_cfg_pkg::ADDR_COUNT, 0);
		`CHK("count_stopped", 32'h0, rdv)
		`CHK("iae_off", 1'b0, illegalAccessEn)
		apb(0, 8'h20, 0);
		`CHK("unmapped_err", 1'b1, errv)
		`CHK("unmapped_data", 32'h0, rdv)
		apb(0, wdt_cfg_pkg::ADDR_MASK, 0);
		`CHK("mask_reset", 32'h0, rdv)
		apb(1, wdt_cfg_pkg::ADDR_IACTL, 32'h1);
		apb(0, wdt_cfg_pkg::ADDR_IACTL, 0);
		`CHK("iactl_rw", 32'h1, rdv)
		apb(1, wdt_cfg_pkg::ADDR_CLEAR, 32'h55);
		repeat (2) @(posedge clock);
		`CHK("stopped_no_trip", 1'b0, wdtResetReq)
		standbyMode <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			reset_with(opt(0, 3, 1, 7, s));
			`CHK("iae_forced", 1'b1, illegalAccessEn)
			apb(0, wdt_cfg_pkg::ADDR_COUNT, 0);
			c0 = rdv;
			repeat (20) @(posedge clock);
			apb(0, wdt_cfg_pkg::ADDR_COUNT, 0);
			`CHK("standby_count", s[0], rdv !== c0)
		end
		standbyMode <= 1'b0;
		reset_with(opt(1, 3, 1, 0, 1));
		apb(1, wdt_cfg_pkg::ADDR_MASK, 32'h1);
		n = 0;
		while (irq !== 1'b1 && n < 200) begin @(negedge clock); n++; end
		`CHK("irq_interval", 1'b1, irq)
		apb(0, wdt_cfg_pkg::ADDR_STATUS, 0);
		`CHK("status_interval", 32'h1, rdv)
		apb(1, wdt_cfg_pkg::ADDR_CLEAR, {24'h0, wdt_cfg_pkg::CLEAR_KEY});
		apb(1, wdt_cfg_pkg::ADDR_MASK, 32'h0);
		@(posedge clock);
		`CHK("irq_masked", 1'b0, irq)
		apb(1, wdt_cfg_pkg::ADDR_STATUS, 32'h1);
		apb(0, wdt_cfg_pkg::ADDR_STATUS, 0);
		`CHK("status_w1c", 32'h0, rdv)
		`CHK("key_cleared", 1'b0, wdtResetReq)
		c = $urandom_range(2, 0);
		reset_with(opt(0, 3, 1, c, 1));
		apb(1, wdt_cfg_pkg::ADDR_MASK, 32'h2);
		n = 0;
		while (wdtResetReq !== 1'b1 && n < 1200) begin @(negedge clock); n++; end
		c0 = period(c) * Div;
		`CHK("ovf_time", 1'b1, n > c0 - 16 && n < c0 + 8)
		apb(0, wdt_cfg_pkg::ADDR_STATUS, 0);
		`CHK("status_ovf", 32'h2, rdv)
		`CHK("irq_ovf", 1'b1, irq)
		// The 75 % rows clear well away from the quarter point
		for (int i = 0; i < 7; i++) begin
			reset_with(opt(0, tWin[i], 1, 0, tSb[i]));
			repeat (tWait[i]) @(posedge clock);
			wd = $urandom;
			if (tKey[i] == 1) wd[7:0] = wdt_cfg_pkg::CLEAR_KEY;
			else if (wd[7:0] == wdt_cfg_pkg::CLEAR_KEY) wd[7:0] = 8'h00;
			apb(1, wdt_cfg_pkg::ADDR_CLEAR, wd);
			repeat (3) @(posedge clock);
			`CHK("window_trip", tTrip[i] == 1, wdtResetReq)
			apb(0, wdt_cfg_pkg::ADDR_STATUS, 0);
			`CHK("window_flag", tTrip[i] == 1, rdv[wdt_cfg_pkg::ST_WINDOW])
		end
		tally_and_finish();
	end
endmodule // tb_top
